// ### core/gca_pkg.sv
// shared constants and types of the bus port engine host sequencer
package gca_pkg;

	// ----------------------------------------------------------------
	// register map of the bus_port_engine (3-bit register select)
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_DATA_IN = 3'h0; // data_input_reg on read
	localparam logic [2:0] REG_CMD_OUT = 3'h0; // cmd_data_out_reg on write
	localparam logic [2:0] REG_IRQ_STATUS_1 = 3'h1; // irq_status_1 on read
	localparam logic [2:0] REG_IRQ_STATUS_2 = 3'h2; // irq_status_2 on read
	localparam logic [2:0] REG_ADDR_STATUS = 3'h4; // address_status_reg on read
	localparam logic [2:0] REG_ADDR_SETUP = 3'h4; // address_setup_reg on write
	localparam logic [2:0] REG_PASSTHRU = 3'h5; // passthrough_cmd_reg on read
	localparam logic [2:0] REG_AUX_CMD = 3'h5; // aux_command_port on write
	localparam logic [2:0] REG_OWN_ADDR = 3'h6; // own_address_0/1 on write
	localparam logic [2:0] REG_BOARD_SETUP1 = 3'h7; // board_setup_1 on write
	localparam logic [2:0] REG_BOARD_STATUS = 3'h7; // board status on read

	// ----------------------------------------------------------------
	// status bit masks
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_CMD_OUT_READY = 8'h08; // irq_status_2
	localparam logic [7:0] MASK_SEC_PENDING = 8'h04; // irq_status_2
	localparam logic [7:0] MASK_TALK_TAKEN = 8'h02; // irq_status_1
	localparam logic [7:0] MASK_END = 8'h10; // irq_status_1
	localparam logic [7:0] MASK_SYNC_DONE = 8'h01; // board status, sync_done_irq

	// ----------------------------------------------------------------
	// auxiliary command encodings and bus command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] AUX_GO_STANDBY = 8'h10;
	localparam logic [7:0] AUX_TAKE_ASYNC = 8'h11;
	localparam logic [7:0] AUX_TAKE_SYNC = 8'h12;
	localparam logic [7:0] AUX_LISTEN = 8'h13;
	localparam logic [7:0] AUX_LOCAL_UNLISTEN = 8'h1c;
	localparam logic [7:0] AUX_LISTEN_CONT = 8'h1b;
	localparam logic [7:0] AUX_FINISH_HS = 8'h03;
	localparam logic [7:0] AUX_VALID = 8'h0f;
	localparam logic [7:0] AUX_NON_VALID = 8'h07;
	localparam logic [7:0] AUX_HOLDOFF_END = 8'h86; // 100xx110 with xx = 00
	localparam logic [7:0] SET_A_HOLDOFF_ALL = 8'h81; // aux_setting_a holdoff on all data
	localparam logic [7:0] BOARD_CARRY_EN = 8'h04; // carry_cycle_enable
	localparam logic [7:0] TALK_BASE = 8'h40;
	localparam logic [7:0] LISTEN_BASE = 8'h20;
	localparam logic [7:0] CMD_TAKE_CTRL = 8'h09;

	// ----------------------------------------------------------------
	// timing: read strobe width covers access time plus two sync stages
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int RD_ACCESS_NS = 100;
	localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] RD_LAST_CNT = 4'(RD_ACCESS_CYC + 2 - 1);
	localparam logic [1:0] STEP_IDX_RESET = 2'h0;

	// ----------------------------------------------------------------
	// orders, steps and pin group
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_STANDBY_TALK, OP_STANDBY_LISTEN, OP_STANDBY_CONT, OP_TAKE_ASYNC,
		OP_TAKE_SYNC, OP_BLOCK_SETUP, OP_BLOCK_FINISH, OP_PASS_CTRL,
		OP_SEC_SERVICE, OP_LISTEN, OP_UNLISTEN, OP_ADDR_SETUP
	} gca_op_t;

	typedef enum logic [1:0] {K_WRITE, K_POLL, K_READ} gca_kind_t;

	typedef struct packed {
		gca_kind_t kind;
		logic [2:0] addr;
		logic [7:0] data; // write byte or poll mask
		logic cap_sel; // read target: 0 address status, 1 passthrough
		logic last;
	} gca_step_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} gca_bus_t;

	localparam gca_bus_t BUS_IDLE = '{addr: 3'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};

endpackage

// ### core/gca_host_ctrl.sv
// host sequencer that drives the bus port engine through its register pins

module gca_host_ctrl (
	input wire logic clock,
	input wire logic rst,
	input wire logic op_valid,
	input wire gca_pkg::gca_op_t op_code,
	input wire logic [7:0] op_arg,
	input wire logic [4:0] own_addr,
	output gca_pkg::gca_bus_t dev_bus,
	input wire logic [7:0] dev_rdata,
	output logic busy,
	output logic done,
	output logic [7:0] addr_status_seen,
	output logic [7:0] passthru_seen
);

	// ----------------------------------------------------------------
	// pin synchroniser for read data
	// ----------------------------------------------------------------
	logic [7:0] rdata_meta;
	logic [7:0] rdata_sync;

	// the first stage feeds only the second
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_meta <= 8'h00;
			rdata_sync <= 8'h00;
		end else begin
			rdata_meta <= dev_rdata;
			rdata_sync <= rdata_meta;
		end
	end

	// ----------------------------------------------------------------
	// step table: each order is a short list of writes, polls and reads
	// ----------------------------------------------------------------
	typedef enum {S_IDLE, S_ISSUE, S_WR, S_RD} gca_state_t;

	gca_state_t state, next_state;
	gca_pkg::gca_op_t op_q, next_op_q;
	logic [7:0] arg_q, next_arg_q;
	logic [1:0] idx, next_idx;
	logic [3:0] cnt, next_cnt;
	gca_pkg::gca_bus_t next_dev_bus;
	logic next_busy, next_done;
	logic [7:0] next_addr_status_seen, next_passthru_seen;
	gca_pkg::gca_step_t st;

	function automatic gca_pkg::gca_step_t mk(gca_pkg::gca_kind_t k, logic [2:0] a, logic [7:0] d, logic l);
		gca_pkg::gca_step_t s;
		s.kind = k;
		s.addr = a;
		s.data = d;
		s.cap_sel = 1'b0;
		s.last = l;
		return s;
	endfunction

	// current step from order, index, argument and captured secondary
	always_comb begin
		logic [7:0] talk_own;
		logic [7:0] listen_own;
		talk_own = gca_pkg::TALK_BASE | {3'b000, own_addr};
		listen_own = gca_pkg::LISTEN_BASE | {3'b000, own_addr};
		st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, 8'h00, 1'b1);
		unique case (op_q)
			gca_pkg::OP_STANDBY_TALK, gca_pkg::OP_STANDBY_LISTEN: begin
				// address then standby, each gated by ready
				unique case (idx)
					2'd0, 2'd2: st = mk(gca_pkg::K_POLL, gca_pkg::REG_IRQ_STATUS_2, gca_pkg::MASK_CMD_OUT_READY, 1'b0);
					2'd1: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_CMD_OUT,
						(op_q == gca_pkg::OP_STANDBY_TALK) ? talk_own : listen_own, 1'b0);
					// standby issued only after ready seen
					default: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::AUX_GO_STANDBY, 1'b1);
				endcase
			end
			gca_pkg::OP_STANDBY_CONT: begin
				unique case (idx)
					2'd0: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::AUX_LISTEN_CONT, 1'b0);
					2'd1: st = mk(gca_pkg::K_POLL, gca_pkg::REG_IRQ_STATUS_2, gca_pkg::MASK_CMD_OUT_READY, 1'b0);
					default: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::AUX_GO_STANDBY, 1'b1);
				endcase
			end
			gca_pkg::OP_TAKE_ASYNC: begin
				// wait last byte taken before async take
				unique case (idx)
					2'd0: st = mk(gca_pkg::K_POLL, gca_pkg::REG_IRQ_STATUS_1, gca_pkg::MASK_TALK_TAKEN, 1'b0);
					2'd1: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::AUX_TAKE_ASYNC, 1'b0);
					default: st = mk(gca_pkg::K_POLL, gca_pkg::REG_IRQ_STATUS_2, gca_pkg::MASK_CMD_OUT_READY, 1'b1);
				endcase
			end
			gca_pkg::OP_TAKE_SYNC: begin
				// caller issues this before the final read
				if (idx == 2'd0) begin
					st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::AUX_TAKE_SYNC, 1'b0);
				end else begin
					st = mk(gca_pkg::K_POLL, gca_pkg::REG_IRQ_STATUS_2, gca_pkg::MASK_CMD_OUT_READY, 1'b1);
				end
			end
			gca_pkg::OP_BLOCK_SETUP: begin
				// end holdoff; carry setup, arg bit 0 selects carry
				unique case (idx)
					2'd0: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::AUX_HOLDOFF_END, !arg_q[0]);
					2'd1: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::SET_A_HOLDOFF_ALL, 1'b0);
					default: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_BOARD_SETUP1, gca_pkg::BOARD_CARRY_EN, 1'b1);
				endcase
			end
			gca_pkg::OP_BLOCK_FINISH: begin
				// wait END (arg bit 1 low) or sync done, then take and finish
				unique case (idx)
					2'd0: st = arg_q[1] ?
						mk(gca_pkg::K_POLL, gca_pkg::REG_BOARD_STATUS, gca_pkg::MASK_SYNC_DONE, 1'b0) :
						mk(gca_pkg::K_POLL, gca_pkg::REG_IRQ_STATUS_1, gca_pkg::MASK_END, 1'b0);
					2'd1: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::AUX_TAKE_SYNC, 1'b0);
					default: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::AUX_FINISH_HS, 1'b1);
				endcase
			end
			gca_pkg::OP_PASS_CTRL: begin
				// target talk address, then take-control byte
				unique case (idx)
					2'd0, 2'd2: st = mk(gca_pkg::K_POLL, gca_pkg::REG_IRQ_STATUS_2, gca_pkg::MASK_CMD_OUT_READY, 1'b0);
					2'd1: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_CMD_OUT,
						gca_pkg::TALK_BASE | {3'b000, arg_q[4:0]}, 1'b0);
					default: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_CMD_OUT, gca_pkg::CMD_TAKE_CTRL, 1'b1);
				endcase
			end
			gca_pkg::OP_SEC_SERVICE: begin
				// read state, compare secondary, answer valid or not
				unique case (idx)
					2'd0: st = mk(gca_pkg::K_POLL, gca_pkg::REG_IRQ_STATUS_2, gca_pkg::MASK_SEC_PENDING, 1'b0);
					2'd1: st = mk(gca_pkg::K_READ, gca_pkg::REG_ADDR_STATUS, 8'h00, 1'b0);
					2'd2: begin
						st = mk(gca_pkg::K_READ, gca_pkg::REG_PASSTHRU, 8'h00, 1'b0);
						st.cap_sel = 1'b1;
					end
					default: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD,
						(passthru_seen == arg_q) ? gca_pkg::AUX_VALID : gca_pkg::AUX_NON_VALID, 1'b1);
				endcase
			end
			// listener on and off as active controller
			gca_pkg::OP_LISTEN: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::AUX_LISTEN, 1'b1);
			gca_pkg::OP_UNLISTEN: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, gca_pkg::AUX_LOCAL_UNLISTEN, 1'b1);
			// addressing mode, talk-only or listen-only in arg
			gca_pkg::OP_ADDR_SETUP: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_ADDR_SETUP, arg_q, 1'b1);
			default: st = mk(gca_pkg::K_WRITE, gca_pkg::REG_AUX_CMD, 8'h00, 1'b1);
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer: one register access at a time
	// ----------------------------------------------------------------
	// every auxiliary command goes out as one write strobe
	always_comb begin
		next_state = state;
		next_op_q = op_q;
		next_arg_q = arg_q;
		next_idx = idx;
		next_cnt = cnt;
		next_dev_bus = dev_bus;
		next_busy = busy;
		next_done = 1'b0;
		next_addr_status_seen = addr_status_seen;
		next_passthru_seen = passthru_seen;
		unique case (state)
			S_IDLE: begin
				if (op_valid) begin
					next_op_q = op_code;
					next_arg_q = op_arg;
					next_idx = gca_pkg::STEP_IDX_RESET;
					next_busy = 1'b1;
					next_state = S_ISSUE;
				end
			end
			S_ISSUE: begin
				next_dev_bus.addr = st.addr;
				next_dev_bus.wdata = st.data;
				next_cnt = 4'h0;
				if (st.kind == gca_pkg::K_WRITE) begin
					next_dev_bus.wr = 1'b1;
					next_state = S_WR;
				end else begin
					next_dev_bus.rd = 1'b1;
					next_state = S_RD;
				end
			end
			S_WR: begin
				next_dev_bus.wr = 1'b0;
				next_state = S_ISSUE;
				next_idx = idx + 2'd1;
				if (st.last) begin
					next_state = S_IDLE;
					next_busy = 1'b0;
					next_done = 1'b1;
				end
			end
			S_RD: begin
				next_cnt = cnt + 4'h1;
				if (cnt == gca_pkg::RD_LAST_CNT) begin
					// sampled after access time plus the two sync stages
					next_dev_bus.rd = 1'b0;
					next_state = S_ISSUE;
					if (st.kind == gca_pkg::K_READ) begin
						if (st.cap_sel) begin
							next_passthru_seen = rdata_sync;
						end else begin
							next_addr_status_seen = rdata_sync;
						end
					end
					// a poll that misses simply re-reads; no timeout by design
					if (st.kind == gca_pkg::K_READ || (rdata_sync & st.data) != 8'h00) begin
						next_idx = idx + 2'd1;
						if (st.last) begin
							next_state = S_IDLE;
							next_busy = 1'b0;
							next_done = 1'b1;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
			op_q <= gca_pkg::OP_LISTEN;
			arg_q <= 8'h00;
			idx <= gca_pkg::STEP_IDX_RESET;
			cnt <= 4'h0;
			dev_bus <= gca_pkg::BUS_IDLE;
			busy <= 1'b0;
			done <= 1'b0;
			addr_status_seen <= 8'h00;
			passthru_seen <= 8'h00;
		end else begin
			state <= next_state;
			op_q <= next_op_q;
			arg_q <= next_arg_q;
			idx <= next_idx;
			cnt <= next_cnt;
			dev_bus <= next_dev_bus;
			busy <= next_busy;
			done <= next_done;
			addr_status_seen <= next_addr_status_seen;
			passthru_seen <= next_passthru_seen;
		end
	end

endmodule

// ### bench/gca_host_ctrl_sva.sv
// checker of the host sequencer port behaviour
module gca_host_ctrl_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic op_valid,
	input wire gca_pkg::gca_op_t op_code,
	input wire logic [7:0] op_arg,
	input wire logic [4:0] own_addr,
	input wire gca_pkg::gca_bus_t dev_bus,
	input wire logic [7:0] dev_rdata,
	input wire logic busy,
	input wire logic done,
	input wire logic [7:0] addr_status_seen,
	input wire logic [7:0] passthru_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rdy, next_rdy, tkn, next_tkn, aux;
	logic [7:0] lw, next_lw;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	assign aux = dev_bus.wr && dev_bus.addr == gca_pkg::REG_AUX_CMD;
	// a write uses up what earlier polls have shown, so each command byte, standby or async take needs a fresh poll
	always_comb begin
		next_rdy = rdy && !dev_bus.wr;
		next_tkn = tkn && !dev_bus.wr;
		next_lw = dev_bus.wr ? dev_bus.wdata : lw;
		if (dev_bus.rd && dev_bus.addr == gca_pkg::REG_IRQ_STATUS_2 && dev_rdata[3])
			next_rdy = 1'b1;
		if (dev_bus.rd && dev_bus.addr == gca_pkg::REG_IRQ_STATUS_1 && dev_rdata[1])
			next_tkn = 1'b1;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdy <= 1'b0;
			tkn <= 1'b0;
			lw <= 8'h00;
		end else begin
			rdy <= next_rdy;
			tkn <= next_tkn;
			lw <= next_lw;
		end
	end
	sequence s_strobe;
		dev_bus.rd [*7] ##1 !dev_bus.rd;
	endsequence
	sequence s_write_done;
		##2 (aux && dev_bus.wdata == gca_pkg::AUX_LISTEN) ##1 done;
	endsequence
	a_wr_single: assert property (dev_bus.wr |=> !dev_bus.wr)
		else $error("write strobe too long");
	a_rd_width: assert property ($rose(dev_bus.rd) |-> s_strobe)
		else $error("read strobe width wrong");
	a_rd_addr_held: assert property (dev_bus.rd && $past(dev_bus.rd) |-> $stable(dev_bus.addr))
		else $error("select moved during read");
	a_cmd_after_ready: assert property (dev_bus.wr && dev_bus.addr == gca_pkg::REG_CMD_OUT |-> rdy)
		else $error("command byte without ready");
	a_standby_ready: assert property (aux && dev_bus.wdata == gca_pkg::AUX_GO_STANDBY |-> rdy)
		else $error("standby without ready");
	a_async_after_taken: assert property (aux && dev_bus.wdata == gca_pkg::AUX_TAKE_ASYNC |-> tkn)
		else $error("async take before byte taken");
	a_finish_after_sync: assert property (aux && dev_bus.wdata == gca_pkg::AUX_FINISH_HS |-> lw == gca_pkg::AUX_TAKE_SYNC)
		else $error("finish not after sync take");
	a_carry_after_hold: assert property (dev_bus.wr && dev_bus.wdata == gca_pkg::BOARD_CARRY_EN
		&& dev_bus.addr == gca_pkg::REG_BOARD_SETUP1 |-> lw == gca_pkg::SET_A_HOLDOFF_ALL)
		else $error("carry enable before holdoff");
	a_listen_write: assert property (op_valid && !busy && op_code == gca_pkg::OP_LISTEN |-> s_write_done)
		else $error("listen order timing wrong");
	a_take_order: assert property (op_valid && !busy |=> busy)
		else $error("order not taken");
	a_done_ends_busy: assert property (done |-> !busy && $past(busy))
		else $error("done without busy");
endmodule
bind gca_host_ctrl gca_host_ctrl_sva u_sva (.clock(clock), .rst(rst), .op_valid(op_valid), .op_code(op_code),
	.op_arg(op_arg), .own_addr(own_addr), .dev_bus(dev_bus), .dev_rdata(dev_rdata), .busy(busy), .done(done),
	.addr_status_seen(addr_status_seen), .passthru_seen(passthru_seen));

// ### bench/gca_dev_model.sv
// behavioural bus port engine seen through its register pins
module gca_dev_model (
	input wire logic clock,
	input wire logic rst,
	input wire gca_pkg::gca_bus_t dev_bus,
	output logic [7:0] dev_rdata,
	input wire logic [7:0] flags,
	input wire logic [7:0] ast,
	input wire logic [7:0] pt,
	input wire logic [4:0] lat
);
	timeunit 1ns;
	timeprecision 1ps;
	logic atn, pend, rdy;
	logic [4:0] cnt;
	logic [7:0] val, last;
	// released read bus toggles so a stale byte never passes
	assign dev_rdata = dev_bus.rd ? val : ~last;
	assign rdy = atn && cnt >= lat;
	// register read mux
	always_comb begin
		case (dev_bus.addr)
			gca_pkg::REG_IRQ_STATUS_1: val = flags & (gca_pkg::MASK_TALK_TAKEN | gca_pkg::MASK_END);
			gca_pkg::REG_IRQ_STATUS_2: val = {4'h0, rdy, pend, 2'h0};
			gca_pkg::REG_ADDR_STATUS: val = ast;
			gca_pkg::REG_PASSTHRU: val = pt;
			gca_pkg::REG_BOARD_STATUS: val = flags & gca_pkg::MASK_SYNC_DONE;
			default: val = 8'h5a;
		endcase
	end
	// controller state; lat sets how slowly a byte is accepted
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			atn <= 1'b1;
			pend <= 1'b0;
			cnt <= 5'h00;
			last <= 8'h00;
		end else begin
			last <= dev_rdata;
			cnt <= dev_bus.wr ? 5'h00 : cnt + 5'(cnt != 5'h1f);
			if (flags[2])
				pend <= 1'b1;
			if (dev_bus.wr && dev_bus.addr == gca_pkg::REG_AUX_CMD) begin
				if (dev_bus.wdata == gca_pkg::AUX_GO_STANDBY)
					atn <= 1'b0;
				// take control, async or sync, raises atn on the write itself
				if (dev_bus.wdata == gca_pkg::AUX_TAKE_ASYNC || dev_bus.wdata == gca_pkg::AUX_TAKE_SYNC)
					atn <= 1'b1;
				if (dev_bus.wdata == gca_pkg::AUX_VALID || dev_bus.wdata == gca_pkg::AUX_NON_VALID)
					pend <= 1'b0;
			end
			if (dev_bus.wr && dev_bus.addr == gca_pkg::REG_CMD_OUT && dev_bus.wdata == gca_pkg::CMD_TAKE_CTRL)
				atn <= 1'b0;
		end
	end
endmodule

// ### bench/tb.sv
// self-checking bench for the host sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst, op_valid, busy, done;
	gca_pkg::gca_op_t op_code;
	gca_pkg::gca_bus_t dev_bus;
	logic [7:0] op_arg, dev_rdata, ast_seen, pt_seen, flags, ast, pt;
	logic [4:0] own_addr, lat;
	logic [10:0] exp_q[$], got_q[$];
	int err_total, comparisons;
	gca_host_ctrl DUT (.clock(clock), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_arg(op_arg),
		.own_addr(own_addr), .dev_bus(dev_bus), .dev_rdata(dev_rdata), .busy(busy), .done(done),
		.addr_status_seen(ast_seen), .passthru_seen(pt_seen));
	gca_dev_model u_dev (.clock(clock), .rst(rst), .dev_bus(dev_bus), .dev_rdata(dev_rdata), .flags(flags),
		.ast(ast), .pt(pt), .lat(lat));
	always #10 clock = ~clock;
	// writes logged mid-cycle, clear of the launching edge
	always @(negedge clock)
		if (dev_bus.wr === 1'b1)
			got_q.push_back({dev_bus.addr, dev_bus.wdata});
	task automatic chk(input string what, input logic [10:0] got, input logic [10:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic void w(input logic [2:0] a, input logic [7:0] d);
		exp_q.push_back({a, d});
	endfunction
	function automatic void x(input logic [7:0] d);
		w(gca_pkg::REG_AUX_CMD, d);
	endfunction
	// reference: the writes the host owes the port for each order
	function automatic void plan(input gca_pkg::gca_op_t op, input logic [7:0] arg);
		logic [7:0] me;
		me = {3'h0, own_addr};
		case (op)
			gca_pkg::OP_STANDBY_TALK, gca_pkg::OP_STANDBY_LISTEN: begin
				w(gca_pkg::REG_CMD_OUT, me | (op == gca_pkg::OP_STANDBY_TALK ? gca_pkg::TALK_BASE : gca_pkg::LISTEN_BASE));
				x(gca_pkg::AUX_GO_STANDBY);
			end
			gca_pkg::OP_STANDBY_CONT: begin
				x(gca_pkg::AUX_LISTEN_CONT);
				x(gca_pkg::AUX_GO_STANDBY);
			end
			gca_pkg::OP_TAKE_ASYNC: x(gca_pkg::AUX_TAKE_ASYNC);
			gca_pkg::OP_TAKE_SYNC: x(gca_pkg::AUX_TAKE_SYNC);
			gca_pkg::OP_LISTEN: x(gca_pkg::AUX_LISTEN);
			gca_pkg::OP_UNLISTEN: x(gca_pkg::AUX_LOCAL_UNLISTEN);
			gca_pkg::OP_ADDR_SETUP: w(gca_pkg::REG_ADDR_SETUP, arg);
			gca_pkg::OP_BLOCK_SETUP: begin
				x(gca_pkg::AUX_HOLDOFF_END);
				if (arg[0]) begin
					x(gca_pkg::SET_A_HOLDOFF_ALL);
					w(gca_pkg::REG_BOARD_SETUP1, gca_pkg::BOARD_CARRY_EN);
				end
			end
			gca_pkg::OP_BLOCK_FINISH: begin
				x(gca_pkg::AUX_TAKE_SYNC);
				x(gca_pkg::AUX_FINISH_HS);
			end
			gca_pkg::OP_PASS_CTRL: begin
				w(gca_pkg::REG_CMD_OUT, gca_pkg::TALK_BASE | {3'h0, arg[4:0]});
				w(gca_pkg::REG_CMD_OUT, gca_pkg::CMD_TAKE_CTRL);
			end
			default: x(pt == arg ? gca_pkg::AUX_VALID : gca_pkg::AUX_NON_VALID);
		endcase
	endfunction
	// one order: request, bounded wait for done, then every write compared
	task automatic run(input gca_pkg::gca_op_t op, input logic [7:0] arg);
		int n;
		plan(op, arg);
		op_code = op;
		op_arg = arg;
		op_valid = 1'b1;
		@(posedge clock);
		#1 op_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(posedge clock);
			#1 n++;
		end
		chk("done", {10'h0, done}, 11'h001);
		while (exp_q.size() > 0)
			chk("write", got_q.size() > 0 ? got_q.pop_front() : 11'h7ff, exp_q.pop_front());
		chk("extra writes", 11'(got_q.size()), 11'h000);
		got_q = {};
		$display("test %s done", op.name());
	endtask
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		op_valid = 1'b0;
		op_code = gca_pkg::OP_LISTEN;
		op_arg = 8'h00;
		own_addr = 5'h00;
		flags = 8'h00;
		ast = 8'h00;
		pt = 8'h00;
		lat = 5'h01;
		void'($urandom(43821));
		repeat (12) @(posedge clock);
		#1 rst = 1'b0;
		own_addr = 5'($urandom);
		run(gca_pkg::OP_LISTEN, 8'h00);
		run(gca_pkg::OP_UNLISTEN, 8'h00);
		run(gca_pkg::OP_STANDBY_TALK, 8'h00);
		flags = 8'h02;
		run(gca_pkg::OP_TAKE_ASYNC, 8'h00);
		flags = 8'h00;
		lat = 5'd20;
		run(gca_pkg::OP_STANDBY_LISTEN, 8'h00);
		run(gca_pkg::OP_TAKE_SYNC, 8'h00);
		run(gca_pkg::OP_STANDBY_CONT, 8'h00);
		run(gca_pkg::OP_TAKE_SYNC, 8'h00);
		run(gca_pkg::OP_ADDR_SETUP, 8'($urandom));
		run(gca_pkg::OP_BLOCK_SETUP, 8'h00);
		run(gca_pkg::OP_BLOCK_SETUP, 8'h01);
		flags = 8'h10;
		run(gca_pkg::OP_BLOCK_FINISH, 8'h00);
		flags = 8'h01;
		run(gca_pkg::OP_BLOCK_FINISH, 8'h02);
		for (int i = 0; i < 2; i++) begin
			ast = 8'($urandom);
			pt = 8'($urandom);
			flags = 8'h04;
			@(posedge clock);
			#1 flags = 8'h00;
			run(gca_pkg::OP_SEC_SERVICE, i == 0 ? pt : ~pt);
			chk("address status", {3'h0, ast_seen}, {3'h0, ast});
			chk("passthrough", {3'h0, pt_seen}, {3'h0, pt});
		end
		run(gca_pkg::OP_PASS_CTRL, 8'($urandom));
		stop_test();
	end
	// watchdog well beyond the expected run length
	initial begin
		#400000;
		err_total++;
		stop_test();
	end
endmodule
